// >>> magc_adc_model.sv
`timescale 1ns/10ps
// ****************************************
// adc sample source seen by the gain loop
// ****************************************
module magc_adc_model #(
   parameter int PERIOD = 4   // cycles per sample, short for simulation
)(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // control
   input  wire logic        power,
   input  wire logic [15:0] amp,
   // sample stream
   output logic             smp_en,
   output logic      [15:0] smp
);
   int          cnt_q;   // cycles since last sample
   logic        neg_q;   // sign of the next sample
   logic [15:0] last_q;  // last valid sample value

   // one sample per period, only while powered; the source stays on the
   // microphone path, the only routing the loop is meant for
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q  <= 0;
         neg_q  <= 1'b0;
         smp_en <= 1'b0;
         last_q <= 16'h0000;
         smp    <= 16'hffff;
      end else if (power && cnt_q == PERIOD - 1) begin
         cnt_q  <= 0;
         neg_q  <= ~neg_q;
         smp_en <= 1'b1;
         last_q <= neg_q ? -amp : amp;
         smp    <= neg_q ? -amp : amp;
      end else begin
         // outside the strobe the bus carries junk, never the held value
         cnt_q  <= power ? cnt_q + 1 : 0;
         smp_en <= 1'b0;
         smp    <= ~last_q;
      end
   end
endmodule

// >>> magc_avg_filter.sv
`timescale 1ns/10ps
// first-order iir low-pass on the absolute sample value
module magc_avg_filter
   import magc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // sample stream
   input  wire logic        smp_en,
   input  wire logic [15:0] smp,
   input  wire magc_coef_s  coef,
   // mean absolute value
   output logic      [15:0] avg_q
);
   // ****************************************
   // absolute value, saturating -full scale
   // ****************************************
   wire logic [15:0] abs_w = smp[15] ? ((smp == 16'h8000) ? 16'h7fff : (~smp + 16'h0001)) : smp;
   logic [15:0] abs_prev_q;                      // x[n-1]
   // products in 1.15, summed with headroom
   wire logic signed [33:0] acc_w =
      34'($signed({1'b0, abs_w})      * $signed(coef.n0)) +
      34'($signed({1'b0, abs_prev_q}) * $signed(coef.n1)) +
      34'($signed({1'b0, avg_q})      * $signed(coef.d1));
   wire logic signed [18:0] sh_w = acc_w[33:15];
   // clamp to positive range, the mean of magnitudes is never negative
   wire logic [15:0] y_w = sh_w[18] ? 16'h0000 : ((|sh_w[17:15]) ? 16'h7fff : sh_w[15:0]);

   // update once per sample
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         abs_prev_q <= 16'h0000;
         avg_q      <= 16'h0000;
      end else if (smp_en) begin
         abs_prev_q <= abs_w;
         avg_q      <= y_w;   // R2 R4
      end
   end
endmodule

// >>> magc_pkg.sv
package magc_pkg;
   // ****************************************
   // register offsets, page 0
   // ****************************************
   localparam logic [7:0] ADR_STATUS_FLAGS  = 8'h24;
   localparam logic [7:0] ADR_ADC_SAT       = 8'h27;
   localparam logic [7:0] ADR_NOISE_STATUS  = 8'h2d;
   localparam logic [7:0] ADR_ADC_POWER     = 8'h51;
   localparam logic [7:0] ADR_ENABLE_TARGET = 8'h56;
   localparam logic [7:0] ADR_HYST_THRESH   = 8'h57;
   localparam logic [7:0] ADR_MAX_GAIN      = 8'h58;
   localparam logic [7:0] ADR_ATTACK        = 8'h59;
   localparam logic [7:0] ADR_DECAY         = 8'h5a;
   localparam logic [7:0] ADR_NOISE_DEB     = 8'h5b;
   localparam logic [7:0] ADR_SIGNAL_DEB    = 8'h5c;
   localparam logic [7:0] ADR_APPLIED_GAIN  = 8'h5d;
   // page 4 iir coefficient registers 2..7
   localparam logic [7:0] ADR_COEF_FIRST    = 8'h02;
   localparam logic [7:0] ADR_COEF_LAST     = 8'h07;
   // ****************************************
   // field positions
   // ****************************************
   localparam int BIT_AGC_EN      = 7;
   localparam int BIT_ADC_PWR     = 7;
   localparam int BIT_GAIN_EQ     = 7;
   localparam int BIT_ADC_PWRD    = 6;
   localparam int BIT_AGC_SAT     = 5;
   localparam int BIT_ADC_SATF    = 3;
   localparam int BIT_NOISE_FLAG  = 6;
   localparam int TGT_LSB         = 4;
   localparam int THR_LSB         = 1;
   localparam int HYS_LSB         = 6;
   // ****************************************
   // reset values and step sizes
   // ****************************************
   localparam logic [15:0] COEF_N0_RST = 16'h7fff;
   localparam logic [15:0] COEF_ZERO   = 16'h0000;
   localparam logic [7:0]  REG_RST     = 8'h00;
   localparam logic [6:0]  GAIN_STEP   = 7'h01;   // one 0.5 dB step
   localparam logic [6:0]  GAIN_ZERO   = 7'h00;
   localparam logic [6:0]  GAIN_MAXCODE = 7'h77;  // 59.5 dB
   // time constants scale: rate counter reload = field * 8 samples
   localparam int RATE_SHIFT = 3;
   // debounce scale: field counts in units of 16 samples
   localparam int DEB_SHIFT = 4;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      MAGC_IDLE    = 2'b00,
      MAGC_TRACK   = 2'b01,
      MAGC_SILENCE = 2'b10
   } magc_state_e;

   typedef struct packed {
      logic        agc_en;
      logic [2:0]  target;
      logic [1:0]  hyst;
      logic [4:0]  thresh;
      logic [6:0]  max_gain;
      logic [7:0]  attack;
      logic [7:0]  decay;
      logic [4:0]  noise_deb;
      logic [3:0]  signal_deb;
      logic        adc_pwr;
   } magc_cfg_s;

   typedef struct packed {
      logic [15:0] n0;
      logic [15:0] n1;
      logic [15:0] d1;
   } magc_coef_s;

   // target level in absolute-average units, -5.5 dB at code 0, about 6 dB lower per code
   function automatic logic [15:0] magc_target_lvl(input logic [2:0] code);
      logic [15:0] lvl;
      lvl = 16'h4b3b >> code;  // roughly halving per code, top -5.5 dB
      return lvl;
   endfunction

   // noise threshold, -30 dB .. -72 dB, 6 dB per four codes
   function automatic logic [15:0] magc_thresh_lvl(input logic [4:0] code);
      logic [15:0] lvl;
      lvl = 16'h0409 >> code[4:2];
      return lvl;
   endfunction
endpackage

// >>> magc_regs.sv
`timescale 1ns/10ps
// page-0 and page-4 register file
module magc_regs
   import magc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // register port
   input  wire logic        wr_en,
   input  wire logic        page4,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   // settings out
   output magc_cfg_s        cfg,
   output magc_coef_s       coef
);
   logic [7:0] r_q [0:7];    // 0x51 and 0x56..0x5c, index = offset from 0x56, 0x51 at 7
   logic [7:0] c_q [0:5];    // page 4 registers 2..7
   wire logic [2:0] p0_idx = (addr == ADR_ADC_POWER) ? 3'd7 : 3'(addr - ADR_ENABLE_TARGET);
   wire logic p0_hit = !page4 && ((addr >= ADR_ENABLE_TARGET && addr <= ADR_SIGNAL_DEB) ||
                                  addr == ADR_ADC_POWER);
   wire logic p4_hit = page4 && addr >= ADR_COEF_FIRST && addr <= ADR_COEF_LAST;
   wire logic [2:0] p4_idx = 3'(addr - ADR_COEF_FIRST);

   // writes only; status registers live in the top
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 8; i++) r_q[i] <= REG_RST;
         c_q[0] <= COEF_N0_RST[15:8];
         c_q[1] <= COEF_N0_RST[7:0];
         for (int i = 2; i < 6; i++) c_q[i] <= REG_RST;
      end else if (wr_en && p0_hit) begin
         r_q[p0_idx] <= wdata;
      end else if (wr_en && p4_hit) begin
         c_q[p4_idx] <= wdata;
      end
   end

   // field extraction
   assign cfg.agc_en     = r_q[0][BIT_AGC_EN];
   assign cfg.target     = r_q[0][TGT_LSB +: 3];         // R3
   assign cfg.hyst       = r_q[1][HYS_LSB +: 2];
   assign cfg.thresh     = r_q[1][THR_LSB +: 5];         // R9
   assign cfg.max_gain   = r_q[2][6:0];
   assign cfg.attack     = r_q[3];
   assign cfg.decay      = r_q[4];
   assign cfg.noise_deb  = r_q[5][4:0];
   assign cfg.signal_deb = r_q[6][3:0];
   assign cfg.adc_pwr    = r_q[7][BIT_ADC_PWR];          // R19
   assign coef.n0 = {c_q[0], c_q[1]};                    // R4
   assign coef.n1 = {c_q[2], c_q[3]};
   assign coef.d1 = {c_q[4], c_q[5]};
endmodule

// >>> magc_top.sv
`timescale 1ns/10ps
// Behaviour
// (R1) loop updates once per adc sample
// (R2) amplitude is mean absolute value
// (R3) three-bit target selects eight levels
// (R4) averaging iir uses three 16-bit coefficients
// (R5) attack field sets gain-down rate
// (R6) decay field sets gain-up rate
// (R7) silence sets flag, ramps gain down
// (R8) gain holds 0 dB until signal returns
// (R9) five-bit noise threshold field
// (R10) software pairs low threshold with gain
// (R11) debounce and hysteresis filter silence transitions
// (R12) noise and signal debounce fields
// (R13) software ignores gain while noise flagged
// (R14) gain never exceeds programmed maximum; with the loop off the fixed gain is clamped only at 59.5 dB
// (R15) software uses loop only with mic
// (R16) read-only noise flag bit
// (R17) software configures before adc power-up
// (R18) software keeps target margin below full
// (R19) adc power follows control bit
// (R20) powered state reported read-only
// (R21) oversampling at most 128, rate limit
// (R22) three decimation filter types selectable
// (R23) soft-step, gain-equal flag reported
// (R24) gain clamped, readable, saturation flagged
module magc_top
   import magc_pkg::*;
#(
   parameter int RATIO_MAX  = 128,   // largest oversampling ratio
   parameter int FILT_TYPES = 3      // decimation filter choices
)(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // register port
   input  wire logic        wr_en,
   input  wire logic        page4,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  rdata,
   // adc sample stream
   input  wire logic        smp_en,
   input  wire logic [15:0] smp,
   input  wire logic        adc_sat,
   input  wire logic [7:0]  adc_oversampling_ratio,
   input  wire logic [1:0]  filt_sel,
   input  wire logic [6:0]  fixed_gain,
   // microphone gain amplifier, adc power and decimation filter type
   output logic      [6:0]  gain_q,
   output logic             adc_power_q,
   output logic      [1:0]  filt_type_q
);
   // ****************************************
   // settings and averaging
   // ****************************************
   magc_cfg_s   cfg;      // decoded page-0 fields
   magc_coef_s  coef;     // iir coefficients
   logic [15:0] avg;      // running mean absolute

   // every writable byte of both pages lives here,
   // the read-only status bytes are built further down
   magc_regs u_regs (
      .mclk  (mclk),
      .nrst  (nrst),
      .wr_en (wr_en),
      .page4 (page4),
      .addr  (addr),
      .wdata (wdata),
      .cfg   (cfg),
      .coef  (coef)
   );

   // the mean only moves on real samples while powered,
   // so a powered-down path keeps its last estimate
   magc_avg_filter u_avg (
      .mclk   (mclk),
      .nrst   (nrst),
      .smp_en (smp_en & adc_power_q),
      .smp    (smp),
      .coef   (coef),
      .avg_q  (avg)
   );

   // ****************************************
   // level compare
   // ****************************************
   wire logic [15:0] tgt_w  = magc_target_lvl(cfg.target);        // R3
   wire logic [15:0] thr_w  = magc_thresh_lvl(cfg.thresh);        // R9
   // hysteresis raises the exit level by 0..3 steps of thr/4
   wire logic [15:0] thr_hi = thr_w + 16'((thr_w >> 2) * cfg.hyst); // R11
   // enter below thr_w, leave at thr_hi or above
   wire logic below_thr = avg < thr_w;
   wire logic above_hi  = avg >= thr_hi;
   // a mean right on target leaves the gain alone
   wire logic loud      = avg > tgt_w;                             // R2
   wire logic quiet     = avg < tgt_w;
   // legal limit of the gain
   // codes above 59.5 dB clamp, never wrap
   wire logic [6:0] lim_w = (cfg.max_gain > GAIN_MAXCODE) ? GAIN_MAXCODE : cfg.max_gain;
   wire logic tick = smp_en & adc_power_q;                         // R1

   // ****************************************
   // state
   // ****************************************
   magc_state_e state_q, state_d;
   logic [8:0]  deb_q;        // debounce counter, samples
   logic [10:0] rate_q;       // attack/decay pacing counter
   logic        noise_q;      // silence flag
   logic        sat_q;        // loop at limit
   logic        sat_adc_q;    // adc saturated, sticky until read
   logic        pwr_d1_q;     // power-up status

   // debounce in samples; a zero field means none
   wire logic [8:0] noise_deb_len  = 9'(cfg.noise_deb) << DEB_SHIFT;   // R12
   wire logic [8:0] signal_deb_len = 9'(cfg.signal_deb) << DEB_SHIFT;  // R12
   wire logic deb_done_n = deb_q >= noise_deb_len;
   wire logic deb_done_s = deb_q >= signal_deb_len;
   // long fields trade speed for smoothness
   wire logic [10:0] atk_len = 11'(cfg.attack) << RATE_SHIFT;          // R5
   wire logic [10:0] dec_len = 11'(cfg.decay) << RATE_SHIFT;           // R6

   // next state, debounced silence decisions
   always_comb begin
      state_d = state_q;
      case (state_q)
         MAGC_IDLE: begin
            // loop off: the fixed gain rules
            if (cfg.agc_en) state_d = MAGC_TRACK;
         end
         MAGC_TRACK: begin
            // silence only once the debounce ran out
            if (!cfg.agc_en) state_d = MAGC_IDLE;
            else if (tick && below_thr && deb_done_n) state_d = MAGC_SILENCE;  // R11
         end
         MAGC_SILENCE: begin
            if (!cfg.agc_en) state_d = MAGC_IDLE;
            else if (tick && above_hi && deb_done_s) state_d = MAGC_TRACK;     // R8 R11
         end
         default: state_d = MAGC_IDLE;
      endcase
   end

   // debounce counts while the candidate condition persists
   // it saturates, a long quiet spell cannot wrap it
   wire logic deb_cond = (state_q == MAGC_TRACK) ? below_thr :
                         (state_q == MAGC_SILENCE) ? above_hi : 1'b0;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) deb_q <= 9'h000;
      else if (state_d != state_q || !deb_cond) deb_q <= 9'h000;
      else if (tick && deb_q != 9'h1ff) deb_q <= deb_q + 9'h001;
   end

   // state register, idle after reset
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) state_q <= MAGC_IDLE;
      else state_q <= state_d;
   end

   // ****************************************
   // gain path
   // ****************************************
   // one pacing counter for both directions: a reversal
   // first waits out the count left from the other one
   wire logic rate_hit = (rate_q == 11'h000);
   wire logic [6:0] gain_up = (gain_q < lim_w) ? gain_q + GAIN_STEP : lim_w;
   wire logic [6:0] gain_dn = (gain_q > GAIN_ZERO) ? gain_q - GAIN_STEP : GAIN_ZERO;
   logic [6:0] gain_d;
   logic [6:0] req_w;     // gain requested by loop or fixed setting
   always_comb begin
      gain_d = gain_q;
      req_w  = (fixed_gain > GAIN_MAXCODE) ? GAIN_MAXCODE : fixed_gain;
      case (state_q)
         MAGC_TRACK: begin
            // clamp first, then attack, then decay
            req_w = loud ? gain_dn : (quiet ? gain_up : gain_q);
            if (gain_q > lim_w) gain_d = lim_w;                          // R14
            else if (tick && rate_hit && loud) gain_d = gain_dn;         // R5 R23
            else if (tick && rate_hit && quiet) gain_d = gain_up;        // R6 R23
         end
         MAGC_SILENCE: begin
            // one step per sample, then hold 0 dB
            req_w = GAIN_ZERO;
            if (tick) gain_d = gain_dn;                                  // R7 R8
         end
         default: begin
            // fixed gain, soft-stepped one step per sample
            if (tick && gain_q < req_w) gain_d = gain_q + GAIN_STEP;     // R23
            else if (tick && gain_q > req_w) gain_d = gain_dn;
         end
      endcase
   end

   // gain register; only the clamp acts off a sample tick
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         gain_q <= GAIN_ZERO;
         rate_q <= 11'h000;
      end else begin
         gain_q <= gain_d;                                               // R24
         if (tick) rate_q <= rate_hit ? (loud ? atk_len : dec_len) : rate_q - 11'h001;
      end
   end

   // ****************************************
   // flags and power
   // ****************************************
   // the adc reports powered one cycle after the request settles
   // saturated: the loop wants more than the clamp allows
   wire logic sat_now = (state_q == MAGC_TRACK) && (gain_q >= lim_w) && quiet;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         noise_q     <= 1'b0;
         sat_q       <= 1'b0;
         sat_adc_q   <= 1'b0;
         adc_power_q <= 1'b0;
         pwr_d1_q    <= 1'b0;
         filt_type_q <= 2'b00;
      end else begin
         noise_q     <= (state_d == MAGC_SILENCE);                       // R7 R16
         sat_q       <= sat_now;                                         // R24
         // set wins over a read clear in the same cycle
         if (adc_sat) sat_adc_q <= 1'b1;
         else if (!wr_en && !page4 && addr == ADR_ADC_SAT) sat_adc_q <= 1'b0;
         adc_power_q <= cfg.adc_pwr;                                     // R19
         pwr_d1_q    <= adc_power_q;                                     // R20
         // only offered types and legal oversampling are taken; R21 R22
         if (filt_sel < 2'(FILT_TYPES) && 32'(adc_oversampling_ratio) <= RATIO_MAX)
            filt_type_q <= filt_sel;
      end
   end

   // ****************************************
   // read mux
   // ****************************************
   // status bytes are built live; only the overload bit latches
   wire logic [7:0] stat36 = {(gain_q == req_w), pwr_d1_q, sat_q, 5'h00};  // R20 R23
   wire logic [7:0] stat39 = 8'(sat_adc_q) << BIT_ADC_SATF;
   wire logic [7:0] stat45 = 8'(noise_q) << BIT_NOISE_FLAG;                // R16
   // read data follows addr and page4 in the same cycle
   always_comb begin
      rdata = 8'h00;
      if (!page4) begin
         case (addr)
            ADR_STATUS_FLAGS:  rdata = stat36;
            ADR_ADC_SAT:       rdata = stat39;
            ADR_NOISE_STATUS:  rdata = stat45;
            ADR_ADC_POWER:     rdata = {cfg.adc_pwr, 7'h00};
            ADR_ENABLE_TARGET: rdata = {cfg.agc_en, cfg.target, 4'h0};
            ADR_HYST_THRESH:   rdata = {cfg.hyst, cfg.thresh, 1'b0};
            ADR_MAX_GAIN:      rdata = {1'b0, cfg.max_gain};
            ADR_ATTACK:        rdata = cfg.attack;
            ADR_DECAY:         rdata = cfg.decay;
            ADR_NOISE_DEB:     rdata = {3'h0, cfg.noise_deb};
            ADR_SIGNAL_DEB:    rdata = {4'h0, cfg.signal_deb};
            ADR_APPLIED_GAIN:  rdata = {1'b0, gain_q};                   // R24
            default:           rdata = 8'h00;
         endcase
      end else begin
         case (addr)
            8'h02:   rdata = coef.n0[15:8];
            8'h03:   rdata = coef.n0[7:0];
            8'h04:   rdata = coef.n1[15:8];
            8'h05:   rdata = coef.n1[7:0];
            8'h06:   rdata = coef.d1[15:8];
            8'h07:   rdata = coef.d1[7:0];
            default: rdata = 8'h00;
         endcase
      end
   end

   // ****************************************
   // checks
   // ****************************************
   gain_limit_a: assert property (@(posedge mclk) disable iff (!nrst)  // R14
      (state_q == MAGC_TRACK) |=> gain_q <= $past(lim_w))
      else $error("gain above maximum");
   silence_ramp_a: assert property (@(posedge mclk) disable iff (!nrst)  // R7
      (state_q == MAGC_SILENCE && tick && gain_q != 7'h00) |=> gain_q == $past(gain_q) - 7'h01)
      else $error("silence ramp wrong");
   silence_hold_a: assert property (@(posedge mclk) disable iff (!nrst)  // R8
      (state_q == MAGC_SILENCE && gain_q == 7'h00) |=> gain_q == 7'h00)
      else $error("gain left 0 dB in silence");
   noise_flag_a: assert property (@(posedge mclk) disable iff (!nrst)  // R16
      (state_q == MAGC_SILENCE) |-> noise_q)
      else $error("noise flag not set");
   power_follow_a: assert property (@(posedge mclk) disable iff (!nrst)  // R19
      $rose(cfg.adc_pwr) |=> adc_power_q ##1 pwr_d1_q)
      else $error("power status late");
   gain_step_a: assert property (@(posedge mclk) disable iff (!nrst)  // R1
      !tick && state_q != MAGC_TRACK |=> $stable(gain_q))
      else $error("gain moved between samples");
   applied_read_a: assert property (@(posedge mclk) disable iff (!nrst)  // R24
      (!page4 && addr == ADR_APPLIED_GAIN) |-> rdata == {1'b0, gain_q})
      else $error("applied gain readback");
   attack_dir_a: assert property (@(posedge mclk) disable iff (!nrst)  // R5
      (state_q == MAGC_TRACK && tick && loud && gain_q <= lim_w) |=> gain_q <= $past(gain_q))
      else $error("gain rose while loud");
   cov_silence_c: cover property (@(posedge mclk) disable iff (!nrst) $rose(noise_q));
   cov_attack_c:  cover property (@(posedge mclk) disable iff (!nrst) tick && rate_hit && loud);
   cov_hold_c:    cover property (@(posedge mclk) disable iff (!nrst) noise_q && gain_q == 7'h00);
   cov_exit_c:    cover property (@(posedge mclk) disable iff (!nrst) $fell(noise_q));
   cov_sat_c:     cover property (@(posedge mclk) disable iff (!nrst) $rose(sat_q));
endmodule

// >>> tb.sv
`timescale 1ns/10ps
module tb;
   import magc_pkg::*;
   typedef struct packed {
      logic [1:0] sel;   // 0 rdata, 1 gain, 2 filter type
      logic [7:0] exp;
      logic [7:0] msk;
   } magc_exp_s;
   // ****************************************
   // signals
   // ****************************************
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        wr_en = 1'b0;
   logic        page4 = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic        smp_en;
   logic [15:0] smp;
   logic        adc_sat = 1'b0;
   logic [7:0]  ratio = 8'h80;
   logic [1:0]  filt_sel = 2'h0;
   logic [6:0]  fixed_gain = 7'h00;
   logic [6:0]  gain_q;
   logic        adc_power_q;
   logic [1:0]  filt_type_q;
   logic [15:0] amp = 16'h0000;
   logic        chk_v = 1'b0;
   magc_exp_s   exp_q[$];
   magc_exp_s   cur;
   logic [7:0]  obs;
   logic [7:0]  d;
   logic [7:0]  idle36;   // status byte while idle at 0 dB
   int          error_cnt = 0;
   int          compares = 0;
   int          seed = 45;
   int          cyc = 0;
   logic [7:0]  rmsk[7] = '{8'hf0, 8'hfe, 8'h7f, 8'hff, 8'hff, 8'h1f, 8'h0f};
   logic [7:0]  cfgv[7] = '{8'h00, 8'hc0, 8'h04, 8'h01, 8'h01, 8'h00, 8'h01};
   logic [7:0]  crst[6] = '{8'h7f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0]  p0a[12] = '{8'h24, 8'h27, 8'h2d, 8'h51, 8'h56, 8'h57,
                            8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d};

   always #4 mclk = ~mclk;

   magc_top i_magc_top (.mclk(mclk), .nrst(nrst), .wr_en(wr_en), .page4(page4),
      .addr(addr), .wdata(wdata), .rdata(rdata), .smp_en(smp_en), .smp(smp),
      .adc_sat(adc_sat), .adc_oversampling_ratio(ratio), .filt_sel(filt_sel),
      .fixed_gain(fixed_gain), .gain_q(gain_q), .adc_power_q(adc_power_q),
      .filt_type_q(filt_type_q));

   magc_adc_model i_magc_adc_model (.mclk(mclk), .nrst(nrst), .power(adc_power_q),
      .amp(amp), .smp_en(smp_en), .smp(smp));

   // ****************************************
   // tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic p4);
      @(negedge mclk);
      wr_en = 1'b1;
      addr  = a;
      wdata = v;
      page4 = p4;
      @(negedge mclk);
      wr_en = 1'b0;
   endtask

   // queue the expectation, then let the watcher sample at the next edge
   task automatic chk(input logic [1:0] s, input logic [7:0] a, input logic p4,
                      input logic [7:0] x, input logic [7:0] m);
      @(negedge mclk);
      addr  = a;
      page4 = p4;
      exp_q.push_back(magc_exp_s'{sel: s, exp: x, msk: m});
      chk_v = 1'b1;
      @(negedge mclk);
      chk_v = 1'b0;
   endtask

   // bounded wait for the loop to settle at a gain code
   task automatic wait_gain(input logic [6:0] g);
      int n;
      n = 0;
      while (gain_q !== g && n < 3000) begin
         @(negedge mclk);
         n++;
      end
   endtask

   task automatic give_verdict();
      if (error_cnt == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ****************************************
   // watcher: oldest note against the output
   // ****************************************
   always @(posedge mclk) begin
      if (chk_v) begin
         cur = exp_q.pop_front();
         obs = (cur.sel == 2'd0) ? rdata :
               (cur.sel == 2'd1) ? {1'b0, gain_q} : {6'h00, filt_type_q};
         compares++;
         if ((obs & cur.msk) !== (cur.exp & cur.msk)) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, obs & cur.msk,
                     cur.exp & cur.msk);
         end
      end
   end

   // hang guard, far above the thousand or so cycles the sequence needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         give_verdict();
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      fixed_gain = 7'($random(seed)) & 7'h3f;
      idle36 = {fixed_gain == 7'h00, 7'h00};
      repeat (5) @(negedge mclk);
      nrst = 1'b1;
      // reset contents of both pages
      foreach (p0a[i]) chk(0, p0a[i], 1'b0, i ? 8'h00 : idle36, 8'hff);
      foreach (crst[i]) chk(0, 8'h02 + 8'(i), 1'b1, crst[i], 8'hff);
      // random settings read back through their fields
      for (int i = 0; i < 7; i++) begin
         d = 8'($random(seed));
         wr(8'h56 + 8'(i), d, 1'b0);
         chk(0, 8'h56 + 8'(i), 1'b0, d, rmsk[i]);
         if (i == 0) wr(8'h56, 8'h00, 1'b0);  // keep the loop idle
      end
      for (int i = 0; i < 6; i++) begin
         d = 8'($random(seed));
         wr(8'h02 + 8'(i), d, 1'b1);
         chk(0, 8'h02 + 8'(i), 1'b1, d, 8'hff);
         wr(8'h02 + 8'(i), crst[i], 1'b1);
      end
      // read-only places and an unmapped one take no write
      wr(8'h5d, 8'hff, 1'b0);
      wr(8'h24, 8'hff, 1'b0);
      wr(8'h60, 8'hff, 1'b0);
      chk(0, 8'h5d, 1'b0, 8'h00, 8'hff);
      chk(0, 8'h24, 1'b0, idle36, 8'hff);
      // sticky converter overload, cleared by its read
      @(negedge mclk) adc_sat = 1'b1;
      @(negedge mclk) adc_sat = 1'b0;
      chk(0, 8'h27, 1'b0, 8'h08, 8'h08);
      chk(0, 8'h27, 1'b0, 8'h00, 8'h08);
      // decimation filter choice, refused above the ratio limit
      filt_sel = 2'd1;
      repeat (2) @(negedge mclk);
      chk(2, 8'h00, 1'b0, 8'h01, 8'h03);
      filt_sel = 2'd2;
      ratio    = 8'd129;
      repeat (2) @(negedge mclk);
      chk(2, 8'h00, 1'b0, 8'h01, 8'h03);
      ratio    = 8'd128;
      // loop settings before power-up, loop off first
      foreach (cfgv[i]) wr(8'h56 + 8'(i), cfgv[i], 1'b0);
      amp = 16'h1000;
      wr(ADR_ADC_POWER, 8'h80, 1'b0);
      repeat (2) @(negedge mclk);
      chk(0, 8'h24, 1'b0, 8'h40, 8'h40);
      wait_gain(fixed_gain);
      chk(1, 8'h00, 1'b0, {1'b0, fixed_gain}, 8'h7f);
      // quiet signal between threshold and target: gain climbs to the clamp
      wr(8'h56, 8'h80, 1'b0);
      wait_gain(7'h04);
      repeat (64) @(negedge mclk);
      chk(1, 8'h00, 1'b0, 8'h04, 8'h7f);
      chk(0, 8'h5d, 1'b0, 8'h04, 8'hff);
      chk(0, 8'h24, 1'b0, 8'h20, 8'h20);
      // silence: debounced flag, ramp to 0 dB and hold there
      wr(8'h5b, 8'h01, 1'b0);
      amp = 16'h0000;
      repeat (16) @(negedge mclk);
      chk(0, 8'h2d, 1'b0, 8'h00, 8'h40);
      wait_gain(7'h00);
      chk(0, 8'h2d, 1'b0, 8'h40, 8'h40);
      repeat (120) @(negedge mclk);
      chk(1, 8'h00, 1'b0, 8'h00, 8'h7f);
      // signal returns, flag drops and gain climbs again
      amp = 16'h1000;
      wait_gain(7'h04);
      chk(0, 8'h2d, 1'b0, 8'h00, 8'h40);
      chk(1, 8'h00, 1'b0, 8'h04, 8'h7f);
      // loud average above target: gain pulled down to the floor
      amp = 16'h6000;
      wait_gain(7'h00);
      chk(1, 8'h00, 1'b0, 8'h00, 8'h7f);
      chk(0, 8'h2d, 1'b0, 8'h00, 8'h40);
      // power down reported back
      wr(ADR_ADC_POWER, 8'h00, 1'b0);
      repeat (2) @(negedge mclk);
      chk(0, 8'h24, 1'b0, 8'h00, 8'h40);
      give_verdict();
   end
endmodule
